// File: hdl/usbdr_pkg.sv
// Shared constants for the dual-role link control block.
package usbdr_pkg;
    // ==========================================
    // Register map.
    localparam logic [11:0] OFS_OTG = 12'h000;  // Role and buffer sizing.
    localparam logic [11:0] OFS_EOF = 12'h004;  // Frame guard and soft resets.
    localparam logic [11:0] OFS_STAT = 12'h008; // Block status.
    // ==========================================
    // Field positions.
    localparam int RXDB_BIT = 28;
    localparam int RXSZ_LSB = 24;
    localparam int TXDB_BIT = 20;
    localparam int TXSZ_LSB = 16;
    localparam int TXDMA_BIT = 9;
    localparam int RXDMA_BIT = 8;
    localparam int REQ_BIT = 1;
    localparam int RECRST_BIT = 25;
    localparam int BUSRST_BIT = 24;
    localparam int LSG_LSB = 16;
    localparam int FSG_LSB = 8;
    localparam logic [31:0] EOF_RESET = 32'h0072_7780;
    localparam logic [3:0] SIZE_CODE_MAX = 4'h9;
    localparam logic [13:0] SIZE_UNIT = 14'h0008;
    localparam logic [9:0] PIN_SYNC_RESET = 10'h020; // Pin stages after reset; the B side stage idles high.
    // ==========================================
    // Timing; times are held in tenths of a nanosecond for the guard math.
    localparam int CLK_PERIOD_NS = 50;
    localparam real LS_UNIT_US = 1.067;
    localparam real FS_UNIT_NS = 533.3;
    localparam real HS_UNIT_NS = 133.3;
    localparam int FRAME_FS_US = 1000;
    localparam int FRAME_HS_US = 125;
    localparam logic [31:0] CLK_TNS = 32'(CLK_PERIOD_NS * 10);
    localparam logic [31:0] LS_UNIT_TNS = 32'(int'(LS_UNIT_US * 10000.0));
    localparam logic [31:0] FS_UNIT_TNS = 32'(int'(FS_UNIT_NS * 10.0));
    localparam logic [31:0] HS_UNIT_TNS = 32'(int'(HS_UNIT_NS * 10.0));
    localparam int FRAME_FS_CYC = FRAME_FS_US * 1000 / CLK_PERIOD_NS;
    localparam int FRAME_HS_CYC = FRAME_HS_US * 1000 / CLK_PERIOD_NS;
    // Link speed codes on the speed pins.
    localparam logic [1:0] SPD_HS = 2'h0;
    localparam logic [1:0] SPD_FS = 2'h1;
endpackage : usbdr_pkg

// File: hdl/usbdr_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/1ns
module usbdr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic flush,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("FIFO depth must be a power of two of at least 2.");
    end
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [AW:0] count_r;
    wire push = inValid && inReady;
    wire pop = outValid && outReady;
    // Full and empty come straight from the occupancy count.
    assign inReady = (count_r != (AW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign outData = mem_r[rdPtr_r];
    // Storage is written only on an accepted push.
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_r[wrPtr_r] <= inData;
        end
    end
    // Pointers and count; flush empties the queue at once.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else if (flush) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            wrPtr_r <= wrPtr_r + AW'(push);
            rdPtr_r <= rdPtr_r + AW'(pop);
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : usbdr_fifo

// File: hdl/usbdr_ctrl.sv
// Dual-role link control: buffer sizing, soft resets and frame-end guard.
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ns
module usbdr_ctrl
    import usbdr_pkg::*;
#(
    parameter int FRAME_CYCLES_FS = FRAME_FS_CYC,
    parameter int FIFO_DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] linkSpeedPin,
    input wire logic frameSyncPin,
    input wire logic roleDonePin,
    input wire logic bSidePin,
    input wire logic fsDevPin,
    input wire logic lsDevPin,
    input wire logic [1:0] vbusPin,
    input wire logic hostModePin,
    input wire logic [7:0] rxData,
    input wire logic rxValid,
    input wire logic rxLast,
    output logic rxReady,
    output logic [7:0] epData,
    output logic epValid,
    input wire logic epReady,
    output logic [13:0] rxCapacity,
    output logic [13:0] txCapacity,
    output logic txnStartAllowed,
    output logic recoveredDomainReset,
    output logic busDomainReset,
    output logic sessionRequest,
    output logic roleRequest,
    output logic txEndpointDma,
    output logic rxEndpointDma
);
    if (FRAME_CYCLES_FS < FRAME_HS_CYC || FRAME_CYCLES_FS > 32767) begin : g_bad_frame
        $error("Frame length parameter out of range.");
    end

    // ==========================================
    // Pin synchronisers.
    // Every pin passes two flops; only the second stage is read.
    logic [9:0] pinMeta_r;
    logic [9:0] pinSync_r;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            // The B side stage resets high so the indication never dips to zero while the stages fill.
            pinMeta_r <= PIN_SYNC_RESET;
            pinSync_r <= PIN_SYNC_RESET;
        end else begin
            pinMeta_r <= {linkSpeedPin, frameSyncPin, roleDonePin, bSidePin,
                          fsDevPin, lsDevPin, vbusPin, hostModePin};
            pinSync_r <= pinMeta_r;
        end
    end
    // Named views of the synchronised pins.
    wire [1:0] linkSpeed = pinSync_r[9:8];
    wire frameSync = pinSync_r[7];
    wire roleDone = pinSync_r[6];
    wire bSideIn = pinSync_r[5];
    // Edge detectors look only at synchronised levels.
    logic frameSyncD_r;
    logic roleDoneD_r;
    wire frameStart = frameSync && !frameSyncD_r;
    wire roleDoneRise = roleDone && !roleDoneD_r;

    // ==========================================
    // APB decode.
    // Writes land on the access edge; an unmapped offset is refused with an error and no write.
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire hitOtg = (paddr == OFS_OTG);
    wire hitEof = (paddr == OFS_EOF);
    wire hitStat = (paddr == OFS_STAT);
    wire mapped = hitOtg || hitEof || hitStat;
    wire wrOtg = access && pwrite && hitOtg;
    wire wrEof = access && pwrite && hitEof;
    wire wrStat = access && pwrite && hitStat;
    // Zero wait states: read data was latched in the setup cycle.
    assign pready = access;
    assign pslverr = access && !mapped;

    // ==========================================
    // Registers.
    logic [31:0] otg_r;      // Writable role and sizing fields.
    logic [31:0] eof_r;      // Guard fields and soft reset bits.
    logic roleRequest_r;     // Cleared by hardware on role change.
    logic bSide_r;           // Reads one out of reset.
    logic rxOversize_r;      // Sticky, write one to clear.
    logic [31:0] prdata_r;
    logic [31:0] otgView;
    logic [31:0] rdMux;
    // Status pins sit at bits 7 to 2; bit 1 is filled in from the role request flop in the read mux.
    assign otgView = {otg_r[31:8], bSide_r, pinSync_r[4:0], 1'b0, otg_r[0]} & 32'h1F1F_03FF;

    // The writable OTG fields; status bits are masked out of the stored word.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            otg_r <= '0;
        end else if (wrOtg) begin
            otg_r <= pwdata & 32'h1F1F_0301;
        end
    end

    // Guard fields and soft resets; defaults give the nominal windows.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            eof_r <= EOF_RESET;
        end else if (wrEof) begin
            eof_r <= pwdata & 32'h03FF_FFFF;
        end
    end

    // A software write wins over a completing role change in the same cycle.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            roleRequest_r <= 1'b0;
        end else if (wrOtg) begin
            roleRequest_r <= pwdata[REQ_BIT];
        end else if (roleDoneRise) begin
            roleRequest_r <= 1'b0;
        end
    end

    // B side indication: one at reset, then follows the pin.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bSide_r <= 1'b1;
            frameSyncD_r <= 1'b0;
            roleDoneD_r <= 1'b0;
        end else begin
            bSide_r <= bSideIn;
            frameSyncD_r <= frameSync;
            roleDoneD_r <= roleDone;
        end
    end

    // Read mux; the status word shows live block state.
    assign rdMux = hitOtg ? (otgView | {30'h0, roleRequest_r, 1'b0}) :
                   hitEof ? eof_r :
                   hitStat ? {30'h0, txnStartAllowed, rxOversize_r} : 32'h0;

    // Read data is captured in the setup phase so it comes from a flop.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prdata_r <= '0;
        end else if (setup) begin
            prdata_r <= rdMux;
        end
    end
    assign prdata = prdata_r;

    // ==========================================
    // Soft resets and enables.
    assign recoveredDomainReset = eof_r[RECRST_BIT];
    assign busDomainReset = eof_r[BUSRST_BIT];
    assign sessionRequest = otg_r[0];
    assign roleRequest = roleRequest_r;
    assign txEndpointDma = otg_r[TXDMA_BIT];
    assign rxEndpointDma = otg_r[RXDMA_BIT];

    // ==========================================
    // Buffer sizing.
    // Reserved codes clamp to the largest size so sizing never wraps.
    wire [3:0] rxCode = otg_r[RXSZ_LSB +: 4];
    wire [3:0] txCode = otg_r[TXSZ_LSB +: 4];
    wire [3:0] rxCodeEff = (rxCode > SIZE_CODE_MAX) ? SIZE_CODE_MAX : rxCode;
    wire [3:0] txCodeEff = (txCode > SIZE_CODE_MAX) ? SIZE_CODE_MAX : txCode;
    wire [13:0] rxPktMax = SIZE_UNIT << rxCodeEff;
    wire [13:0] txPktMax = SIZE_UNIT << txCodeEff;
    assign rxCapacity = rxPktMax << otg_r[RXDB_BIT];
    assign txCapacity = txPktMax << otg_r[TXDB_BIT];

    // ==========================================
    // Receive path.
    // Bytes flow through a small FIFO; the bus-domain reset flushes it.
    // Limitation: only the receive side carries data; transmit sizing is reported but moves nothing.
    // Four entries absorb a short stall of the endpoint sink without losing a byte.
    logic fifoInReady;
    logic [13:0] pktCount_r;
    usbdr_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_rxFifo (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .flush(busDomainReset),
        .inData(rxData),
        .inValid(rxValid && !busDomainReset),
        .inReady(fifoInReady),
        .outData(epData),
        .outValid(epValid),
        .outReady(epReady)
    );
    assign rxReady = fifoInReady && !busDomainReset;
    wire rxAccept = rxValid && rxReady;
    wire overByte = rxAccept && (pktCount_r >= rxPktMax);

    // Counts bytes of the current packet against the largest packet size.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pktCount_r <= '0;
        end else if (busDomainReset || (rxAccept && rxLast)) begin
            pktCount_r <= '0;
        end else if (rxAccept && !overByte) begin
            pktCount_r <= pktCount_r + 14'h0001;
        end
    end

    // Oversize flag: a new event beats a clear in the same cycle.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rxOversize_r <= 1'b0;
        end else if (overByte) begin
            rxOversize_r <= 1'b1;
        end else if (wrStat && pwdata[0]) begin
            rxOversize_r <= 1'b0;
        end
    end

    // ==========================================
    // Frame timer and end-of-frame guard.
    // The timer counts down to frame end; a frame sync realigns it.
    // Times are compared in tenths of a nanosecond, which keeps the fractional guard units exact.
    logic [14:0] frameCnt_r;
    wire isHs = (linkSpeed == SPD_HS);
    wire isFs = (linkSpeed == SPD_FS);
    wire [14:0] frameLast = isHs ? 15'(FRAME_HS_CYC - 1) : 15'(FRAME_CYCLES_FS - 1);
    wire [7:0] guardSel = isHs ? eof_r[7:0] :
                          isFs ? eof_r[FSG_LSB +: 8] : eof_r[LSG_LSB +: 8];
    wire [31:0] unitSel = isHs ? HS_UNIT_TNS : isFs ? FS_UNIT_TNS : LS_UNIT_TNS;
    wire [31:0] guardTns = 32'(guardSel) * unitSel;
    wire [31:0] remainTns = 32'(frameCnt_r) * CLK_TNS;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            frameCnt_r <= '0;
        end else if (busDomainReset || frameStart || frameCnt_r == '0) begin
            frameCnt_r <= frameLast;
        end else begin
            frameCnt_r <= frameCnt_r - 15'h0001;
        end
    end

    // New transactions may start only while more than the guard remains.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            txnStartAllowed <= 1'b0;
        end else begin
            txnStartAllowed <= !busDomainReset && (remainTns > guardTns);
        end
    end

    // ==========================================
    // Checks.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // Marks the first sampled cycle after reset for the reset-value checks.
    logic firstCycle_r;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            firstCycle_r <= 1'b1;
        end else begin
            firstCycle_r <= 1'b0;
        end
    end

    // Named steps of the sizing write and of the packet overfill.
    sequence s_rx_size_write;
        wrOtg && pwdata[RXSZ_LSB +: 4] <= SIZE_CODE_MAX;
    endsequence
    sequence s_over_fill;
        rxAccept && !rxLast && pktCount_r == rxPktMax;
    endsequence

    a_rx_size_calc: assert property (s_rx_size_write |=>
        rxCapacity == (14'h0008 << $past(pwdata[27:24])) << $past(pwdata[28]))
        else $error("RX capacity does not follow the written size.");
    a_tx_reserved_clamp: assert property (wrOtg && pwdata[19:16] > 4'h9 |=>
        txCapacity == (14'h1000 << $past(pwdata[20])))
        else $error("Reserved TX code not clamped to the largest size.");
    a_rec_reset_bit: assert property (wrEof |=>
        recoveredDomainReset == $past(pwdata[25]))
        else $error("Recovered domain reset does not follow its bit.");
    a_bus_reset_flush: assert property (busDomainReset |-> !rxReady ##1 !epValid)
        else $error("Bus domain reset does not empty the receive path.");
    a_guard_defaults: assert property (firstCycle_r |-> eof_r == 32'h0072_7780)
        else $error("Guard fields do not hold their defaults.");
    a_guard_closes: assert property (frameCnt_r == 15'h0001 && guardSel != 8'h00
        && !frameStart |=> !txnStartAllowed)
        else $error("Transactions allowed inside the guard window.");
    a_frame_opens: assert property (frameStart && !busDomainReset ##1 !busDomainReset [*2]
        |-> txnStartAllowed [*2])
        else $error("Frame start does not reopen transactions.");
    a_oversize_flag: assert property (s_over_fill |=> rxOversize_r)
        else $error("Oversize packet not flagged.");
    a_fifo_hold: assert property (epValid && !epReady && !busDomainReset
        |=> epValid && $stable(epData))
        else $error("Endpoint data dropped under back-pressure.");
    a_dma_enable: assert property (wrOtg |=> rxEndpointDma == $past(pwdata[8])
        && txEndpointDma == $past(pwdata[9]))
        else $error("Endpoint DMA enables do not follow the write.");
    a_role_clear: assert property (roleDoneRise && !wrOtg |=> !roleRequest)
        else $error("Role request not cleared after the role change.");
    a_bside_reset: assert property (firstCycle_r |-> bSide_r)
        else $error("B side indication not one after reset.");
    // Further checks on writes, clears, the bus-domain reset and unmapped accesses.
    a_oversize_clear: assert property (wrStat && pwdata[0] && !overByte |=>
        !rxOversize_r)
        else $error("Oversize flag not cleared by a write of one.");
    a_session_bit: assert property (wrOtg |=>
        sessionRequest == $past(pwdata[0]))
        else $error("Session request does not follow the write.");
    a_bus_reset_guard: assert property (busDomainReset |=> !txnStartAllowed)
        else $error("Transactions allowed during a bus domain reset.");
    a_role_write: assert property (wrOtg |=>
        roleRequest == $past(pwdata[REQ_BIT]))
        else $error("Role request does not follow the write.");
    a_unmapped_read: assert property (access && !mapped |-> pslverr && prdata == 32'h0000_0000)
        else $error("Unmapped access not refused.");
endmodule : usbdr_ctrl

// File: test/usbdr_link_partner.sv
// Far-side model that feeds received bytes into the block's receive stream.
`timescale 1ns/1ns
module usbdr_link_partner (
    input wire logic clk_sys,
    input wire logic resetn,
    output logic [7:0] rxData,
    output logic rxValid,
    output logic rxLast,
    input wire logic rxReady
);
    // ==========================================
    // Idle line state.
    // Outside a byte the data shows the inverse of the last byte, so stale data never looks valid.
    initial begin
        rxData = 8'hA5;
        rxValid = 1'b0;
        rxLast = 1'b0;
    end

    // ==========================================
    // Byte transfer.
    // The byte and its end mark are held until the block takes them; a stall costs cycles, never data.
    task automatic send(input logic [7:0] d, input logic last);
        @(posedge clk_sys);
        rxData <= d;
        rxValid <= 1'b1;
        rxLast <= last;
        do @(posedge clk_sys); while (rxReady !== 1'b1);
        rxValid <= 1'b0;
        rxData <= ~d;
        rxLast <= 1'b0;
    endtask : send
endmodule : usbdr_link_partner

// File: test/usbdr_ctrl_test.sv
// Self-checking testbench for the dual-role link control block.
`timescale 1ns/1ns
`define CHECK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] %0t got %0h expected %0h", $time, (a), (b)); end end
module usbdr_ctrl_test;
    import usbdr_pkg::*;
    localparam int FRAME = 3000; // Shortened full-speed frame keeps the run brief.
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, e;
    logic [1:0] linkSpeedPin = 2'h1, vbusPin = 2'h2;
    logic frameSyncPin = 1'b0, roleDonePin = 1'b0, bSidePin = 1'b1, fsDevPin = 1'b0;
    logic lsDevPin = 1'b1, hostModePin = 1'b1, epReady = 1'b0;
    logic [7:0] rxData, epData;
    logic rxValid, rxLast, rxReady, epValid, txnStartAllowed, recoveredDomainReset;
    logic busDomainReset, sessionRequest, roleRequest, txEndpointDma, rxEndpointDma;
    logic [13:0] rxCapacity, txCapacity, cap;
    int errors = 0;
    int compares = 0;

    // ==========================================
    // Clock and design.
    always #25 clk_sys = ~clk_sys;
    usbdr_ctrl #(.FRAME_CYCLES_FS(FRAME), .FIFO_DEPTH(4)) usbdr_ctrl_i (.clk_sys(clk_sys), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .linkSpeedPin(linkSpeedPin), .frameSyncPin(frameSyncPin),
        .roleDonePin(roleDonePin), .bSidePin(bSidePin), .fsDevPin(fsDevPin), .lsDevPin(lsDevPin),
        .vbusPin(vbusPin), .hostModePin(hostModePin), .rxData(rxData), .rxValid(rxValid), .rxLast(rxLast),
        .rxReady(rxReady), .epData(epData), .epValid(epValid), .epReady(epReady), .rxCapacity(rxCapacity),
        .txCapacity(txCapacity), .txnStartAllowed(txnStartAllowed),
        .recoveredDomainReset(recoveredDomainReset), .busDomainReset(busDomainReset),
        .sessionRequest(sessionRequest), .roleRequest(roleRequest), .txEndpointDma(txEndpointDma),
        .rxEndpointDma(rxEndpointDma));
    usbdr_link_partner usbdr_link_partner_i (.clk_sys(clk_sys), .resetn(resetn), .rxData(rxData),
        .rxValid(rxValid), .rxLast(rxLast), .rxReady(rxReady));

    // ==========================================
    // Bus and reporting tasks.
    // One APB transfer; the request stands until pready is seen at a rising edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop

    // Counts allowed cycles over one frame; the count fixes the guard length exactly.
    task automatic guard(input logic [1:0] s, input int g, input int unit, input int frame);
        int n;
        n = 0;
        linkSpeedPin <= s;
        repeat (3) @(posedge clk_sys);
        frameSyncPin <= 1'b1;
        repeat (4) @(posedge clk_sys);
        frameSyncPin <= 1'b0;
        repeat (frame) @(posedge clk_sys);
        repeat (frame) begin
            @(posedge clk_sys);
            n += (txnStartAllowed === 1'b1);
        end
        `CHECK(n, (frame - 1) - g * unit / int'(CLK_TNS))
    endtask : guard

    // ==========================================
    // Watchdog against a hung handshake.
    initial begin
        repeat (60000) @(posedge clk_sys);
        errors++;
        report_and_stop();
    end

    // ==========================================
    // Main sequence.
    initial begin
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (4) @(posedge clk_sys); // Lets the pin synchronisers fill before the first read.
        apb(1'b0, OFS_OTG, 32'h0);
        `CHECK(r, 32'h0000_00B4)
        apb(1'b0, OFS_EOF, 32'h0);
        `CHECK(r, 32'h0072_7780)
        apb(1'b0, 12'h00C, 32'h0);
        `CHECK({e, r}, 33'h1_0000_0000)
        $display("reset values done");
        // Size codes 0 to 10, reserved code 10 among them, with double buffering on one side at a time.
        for (int c = 0; c < 11; c++) begin
            for (int d = 0; d < 2; d++) begin
                apb(1'b1, OFS_OTG, (32'(d) << 28) | (32'(c) << 24) | (32'(1 - d) << 20) | (32'(c) << 16));
                cap = 14'(8 << (c > 9 ? 9 : c));
                `CHECK(rxCapacity, cap << d)
                `CHECK(txCapacity, cap << (1 - d))
            end
        end
        $display("buffer sizing done");
        apb(1'b1, OFS_OTG, 32'h0000_0303);
        `CHECK({roleRequest, sessionRequest, txEndpointDma, rxEndpointDma}, 4'hF)
        roleDonePin <= 1'b1;
        repeat (5) @(posedge clk_sys);
        `CHECK({roleRequest, sessionRequest}, 2'h1)
        roleDonePin <= 1'b0;
        $display("role request done");
        apb(1'b1, OFS_EOF, EOF_RESET | 32'h0200_0000);
        `CHECK({recoveredDomainReset, busDomainReset}, 2'h2)
        apb(1'b1, OFS_EOF, EOF_RESET | 32'h0100_0000);
        `CHECK({recoveredDomainReset, busDomainReset, rxReady}, 3'h2)
        apb(1'b1, OFS_EOF, EOF_RESET);
        `CHECK({busDomainReset, rxReady}, 2'h1)
        $display("soft resets done");
        // Nine bytes with no end mark overrun the 8-byte packet while the sink stalls at first.
        apb(1'b1, OFS_OTG, 32'h0);
        fork
            for (int i = 0; i < 9; i++) usbdr_link_partner_i.send(8'(8'h30 + i), 1'b0);
            begin
                while (rxReady !== 1'b0) @(posedge clk_sys);
                `CHECK(epValid, 1'b1)
                epReady <= 1'b1;
                for (int i = 0; i < 9; i++) begin
                    do @(posedge clk_sys); while (epValid !== 1'b1);
                    `CHECK(epData, 8'(8'h30 + i))
                end
                epReady <= 1'b0;
            end
        join
        apb(1'b0, OFS_STAT, 32'h0);
        `CHECK(r[0], 1'b1)
        apb(1'b1, OFS_STAT, 32'h1);
        apb(1'b0, OFS_STAT, 32'h0);
        `CHECK(r[0], 1'b0)
        $display("receive stream done");
        guard(SPD_HS, 8'h80, int'(HS_UNIT_TNS), FRAME_HS_CYC);
        guard(SPD_FS, 8'h77, int'(FS_UNIT_TNS), FRAME);
        guard(2'h2, 8'h72, int'(LS_UNIT_TNS), FRAME);
        apb(1'b1, OFS_EOF, 32'h0072_FF80);
        guard(SPD_FS, 8'hFF, int'(FS_UNIT_TNS), FRAME);
        $display("frame guard done");
        report_and_stop();
    end
endmodule : usbdr_ctrl_test
